/* src/arc_cfg_regs.sv */
/*
  APB slave holding the range, common-mode, averaging and sleep configuration.
  Assumes an APB master on pclk; registers sit at byte address four times their index.
*/
// Function
// - Channel 1 to 4 ranges in C2h nibbles.
// - Range codes zero to five select spans.
// - Channel 5 to 8 ranges in C3h nibbles.
// - Common-mode spans at bits 7:6, 9:8.
// - Common-mode code zero half, one, two.
// - Wide common-mode enables at bits 2, 3.
// - C4h bit 0 puts device asleep.
// - Averaging fields at C4h bits 5:4, 1.
// - All fields reset to zero.
module arc_cfg_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output arc_pkg::arc_cfg_t cfg
);

  // Bundled request keeps the decode readable.
  arc_pkg::arc_apb_req_t req;
  // Register contents.
  logic [15:0] reg_q [4];
  // Write pulse per register.
  logic [3:0] wr;
  // Address decode result.
  logic [3:0] hit;
  logic mapped;
  logic aligned;
  // Combinational read value.
  logic [31:0] next_prdata;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                 wdata: pwdata, strb: pstrb};

  // Decode uses the index derived from the byte address.
  always_comb begin
    hit = 4'h0;
    aligned = (req.addr[1:0] == 2'h0);
    if (req.addr[11:2] == {2'h0, arc_pkg::IDX_RANGE_LO}) begin
      hit = 4'h1;
    end else if (req.addr[11:2] == {2'h0, arc_pkg::IDX_RANGE_HI}) begin
      hit = 4'h2;
    end else if (req.addr[11:2] == {2'h0, arc_pkg::IDX_CMODE}) begin
      hit = 4'h4;
    end else if (req.addr[11:2] == {2'h0, arc_pkg::IDX_BOOST}) begin
      hit = 4'h8;
    end
    // A byte address off the word grid maps to nothing, even inside the bank.
    // This keeps a stray byte access from landing half a word in the wrong place.
    if (!aligned) begin
      hit = 4'h0;
    end
    mapped = (hit != 4'h0);
  end

  // Writes land only in the access phase of a mapped, ready transfer.
  assign wr = (req.sel && req.enable && req.write && pready) ? hit : 4'h0;

  // One instance per register; the common-mode one drops bits 15 to 10.
  for (genvar i = 0; i < 4; i++) begin : g_reg
    arc_reg16 #(
      .WMASK((i == 2) ? arc_pkg::CMODE_WMASK : 16'hffff)
    ) u_reg (
      .pclk(pclk),
      .presetn(presetn),
      .wr(wr[i]),
      .strb(req.strb[1:0]),
      .wdata(req.wdata[15:0]),
      .q(reg_q[i])
    );
  end

  // Read mux; upper halfword reads as zero.
  always_comb begin
    next_prdata = 32'h0000_0000;
    for (int j = 0; j < 4; j++) begin
      if (hit[j]) begin
        next_prdata = {16'h0000, reg_q[j]};
      end
    end
  end

  // The slave takes no wait state: pready rises in the first access cycle.
  // It is kept low through reset so a master never sees a stale acknowledge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= req.sel && !req.enable;
    end
  end

  // Read data and error are registered in the setup cycle, shown in access.
  // Outside that one cycle both sit at zero, so a late sample cannot pass old data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (req.sel && !req.enable) begin
      prdata <= req.write ? 32'h0000_0000 : next_prdata;
      pslverr <= !mapped;
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Outputs are registered copies; they follow a write by two cycles.
  // Undefined codes are passed through untouched; software must avoid them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else begin
      cfg.span_sel <= {reg_q[1], reg_q[0]};
      cfg.cmode_span_low_group <= reg_q[2][arc_pkg::POS_CM_LO +: 2];
      cfg.cmode_span_high_group <= reg_q[2][arc_pkg::POS_CM_HI +: 2];
      cfg.wide_cmode_on_low_group <= reg_q[2][arc_pkg::POS_WIDE_LO];
      cfg.wide_cmode_on_high_group <= reg_q[2][arc_pkg::POS_WIDE_HI];
      cfg.averaging_setting_a <= reg_q[2][arc_pkg::POS_AVG_A];
      cfg.averaging_setting_b <= reg_q[2][arc_pkg::POS_AVG_B +: 2];
      cfg.full_device_sleep <= reg_q[2][arc_pkg::POS_SLEEP];
    end
  end

  // A completed full write of C2h shows in the channel 1 to 4 ranges two cycles on.
  property p_range_lo;
    @(posedge pclk) disable iff (!presetn)
      (wr[0] && req.strb[1:0] == 2'h3) |-> ##2 cfg.span_sel[15:0] == $past(req.wdata[15:0], 2);
  endproperty
  a_range_lo: assert property (p_range_lo) else $error("low range bank not updated");

  // Channel 5 to 8 ranges follow a full write of C3h.
  property p_range_hi;
    @(posedge pclk) disable iff (!presetn)
      (wr[1] && req.strb[1:0] == 2'h3) |-> ##2 cfg.span_sel[31:16] == $past(req.wdata[15:0], 2);
  endproperty
  a_range_hi: assert property (p_range_hi) else $error("high range bank not updated");

  // Sleep bit follows bit 0 of a C4h write.
  property p_sleep;
    @(posedge pclk) disable iff (!presetn)
      (wr[2] && req.strb[0]) |-> ##2 cfg.full_device_sleep == $past(req.wdata[0], 2);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep bit wrong");

  // Common-mode spans come from bits 7:6 and 9:8.
  property p_cmode;
    @(posedge pclk) disable iff (!presetn)
      (wr[2] && req.strb[1:0] == 2'h3) |-> ##2
        ({cfg.cmode_span_high_group, cfg.cmode_span_low_group} == $past(req.wdata[9:6], 2));
  endproperty
  a_cmode: assert property (p_cmode) else $error("common-mode span wrong");

  // Wide enables come from bits 2 and 3.
  property p_wide;
    @(posedge pclk) disable iff (!presetn)
      (wr[2] && req.strb[0]) |-> ##2
        ({cfg.wide_cmode_on_high_group, cfg.wide_cmode_on_low_group} == $past(req.wdata[3:2], 2));
  endproperty
  a_wide: assert property (p_wide) else $error("wide enable wrong");

  // Averaging fields come from bits 5:4 and 1.
  property p_avg;
    @(posedge pclk) disable iff (!presetn)
      (wr[2] && req.strb[0]) |-> ##2
        ({cfg.averaging_setting_b, cfg.averaging_setting_a} ==
         {$past(req.wdata[5:4], 2), $past(req.wdata[1], 2)});
  endproperty
  a_avg: assert property (p_avg) else $error("averaging fields wrong");

  // Reserved top of C4h never leaves zero.
  property p_resv;
    @(posedge pclk) disable iff (!presetn)
      reg_q[2][15:10] == 6'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits moved");

  // A read of the channel 1 to 4 ranges returns the register in the access phase.
  property p_read;
    @(posedge pclk) disable iff (!presetn)
      (req.sel && !req.enable && !req.write && hit[0]) |=> (pready && prdata == {16'h0000, reg_q[0]});
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  // An unmapped access answers with an error.
  property p_err;
    @(posedge pclk) disable iff (!presetn)
      (req.sel && !req.enable && !mapped) |=> (pready && pslverr);
  endproperty
  a_err: assert property (p_err) else $error("unmapped access without error");

  // A setup cycle is always answered in the very next cycle.
  // No wait state beyond the one access cycle is ever inserted.
  property p_ready_setup;
    @(posedge pclk) disable iff (!presetn)
      (req.sel && !req.enable) |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("setup not answered");

  // The acknowledge is a single-cycle pulse.
  // Holding it would let a master finish two transfers on one answer.
  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  // A read of the channel 5 to 8 ranges returns the register in the access phase.
  property p_read_hi;
    @(posedge pclk) disable iff (!presetn)
      (req.sel && !req.enable && !req.write && hit[1]) |=>
        (pready && prdata == {16'h0000, reg_q[1]});
  endproperty
  a_read_hi: assert property (p_read_hi) else $error("high range read wrong");

  // A read of the common-mode register returns its value, reserved top at zero.
  property p_read_cmode;
    @(posedge pclk) disable iff (!presetn)
      (req.sel && !req.enable && !req.write && hit[2]) |=>
        (pready && prdata == {16'h0000, reg_q[2]});
  endproperty
  a_read_cmode: assert property (p_read_cmode) else $error("common-mode read wrong");

  // The partly described register is plain storage and reads back as written.
  property p_read_boost;
    @(posedge pclk) disable iff (!presetn)
      (req.sel && !req.enable && !req.write && hit[3]) |=>
        (pready && prdata == {16'h0000, reg_q[3]});
  endproperty
  a_read_boost: assert property (p_read_boost) else $error("boost register read wrong");

  // A mapped, aligned access never reports an error.
  property p_err_ok;
    @(posedge pclk) disable iff (!presetn)
      (req.sel && !req.enable && mapped) |=> (pready && !pslverr);
  endproperty
  a_err_ok: assert property (p_err_ok) else $error("error on a mapped access");

  // Read data and error only stand while the acknowledge does.
  property p_rdata_quiet;
    @(posedge pclk) disable iff (!presetn)
      !pready |-> (prdata == 32'h0000_0000 && !pslverr);
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("response outside access");

  // A write answers with zero read data.
  property p_write_read_zero;
    @(posedge pclk) disable iff (!presetn)
      (req.sel && !req.enable && req.write) |=> (prdata == 32'h0000_0000);
  endproperty
  a_write_read_zero: assert property (p_write_read_zero) else $error("write returned data");

  // Without a write pulse no register moves; error transfers leave them alone.
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (wr == 4'h0) |=> ($stable(reg_q[0]) && $stable(reg_q[1]) &&
                        $stable(reg_q[2]) && $stable(reg_q[3]));
  endproperty
  a_hold: assert property (p_hold) else $error("register moved without a write");

  // A low-lane write keeps the high byte.
  property p_lane_keep_hi;
    @(posedge pclk) disable iff (!presetn)
      (wr[3] && req.strb[1:0] == 2'h1) |=> $stable(reg_q[3][15:8]);
  endproperty
  a_lane_keep_hi: assert property (p_lane_keep_hi) else $error("high byte lost");

  // A high-lane write keeps the low byte.
  property p_lane_keep_lo;
    @(posedge pclk) disable iff (!presetn)
      (wr[3] && req.strb[1:0] == 2'h2) |=> $stable(reg_q[3][7:0]);
  endproperty
  a_lane_keep_lo: assert property (p_lane_keep_lo) else $error("low byte lost");

  // Main scenarios.
  c_wr_cmode: cover property (@(posedge pclk) disable iff (!presetn) wr[2]);
  c_wide: cover property (@(posedge pclk) disable iff (!presetn)
    cfg.wide_cmode_on_high_group);
  c_sleep: cover property (@(posedge pclk) disable iff (!presetn) cfg.full_device_sleep);
  c_span12: cover property (@(posedge pclk) disable iff (!presetn)
    cfg.span_sel[3:0] == arc_pkg::SPAN_12V);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule

/* inc/arc_pkg.sv */
/*
  Package for the range and common-mode configuration bank.
  Holds register offsets, field positions, reset values and the bus carrier structs.
  Assumes it is compiled before every file that names it.
*/
package arc_pkg;

  // Printed offsets are not all multiples of four, so they are kept as indices.
  localparam logic [7:0] IDX_RANGE_LO = 8'hc2; // Range selectors, channels 1 to 4.
  localparam logic [7:0] IDX_RANGE_HI = 8'hc3; // Range selectors, channels 5 to 8.
  localparam logic [7:0] IDX_CMODE = 8'hc4; // Common mode, averaging and sleep.
  localparam logic [7:0] IDX_BOOST = 8'hc5; // Init, boost and averaging, laid out in part.

  // Field positions inside the common-mode register.
  localparam int POS_SLEEP = 0; // Full device sleep bit.
  localparam int POS_AVG_A = 1; // Averaging setting a.
  localparam int POS_WIDE_LO = 2; // Wide common mode on, channels 1 to 4.
  localparam int POS_WIDE_HI = 3; // Wide common mode on, channels 5 to 8.
  localparam int POS_AVG_B = 4; // Averaging setting b, two bits.
  localparam int POS_CM_LO = 6; // Common-mode span, channels 1 to 4, two bits.
  localparam int POS_CM_HI = 8; // Common-mode span, channels 5 to 8, two bits.

  // Writable bits of the common-mode register; bits 15 to 10 are held at reset value.
  localparam logic [15:0] CMODE_WMASK = 16'h03ff;

  // Every register resets to zero.
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Range codes.
  localparam logic [3:0] SPAN_5V = 4'h0;
  localparam logic [3:0] SPAN_3V5 = 4'h1;
  localparam logic [3:0] SPAN_2V5 = 4'h2;
  localparam logic [3:0] SPAN_7V = 4'h3;
  localparam logic [3:0] SPAN_10V = 4'h4;
  localparam logic [3:0] SPAN_12V = 4'h5;

  // Common-mode codes.
  localparam logic [1:0] CM_HALF = 2'h0;
  localparam logic [1:0] CM_6V = 2'h1;
  localparam logic [1:0] CM_12V = 2'h2;

  // APB request as seen by the slave.
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } arc_apb_req_t;

  // Decoded configuration handed to the analog side.
  typedef struct packed {
    logic [31:0] span_sel; // Nibble n-1 is the range of channel n.
    logic [1:0] cmode_span_low_group;
    logic [1:0] cmode_span_high_group;
    logic wide_cmode_on_low_group;
    logic wide_cmode_on_high_group;
    logic averaging_setting_a;
    logic [1:0] averaging_setting_b;
    logic full_device_sleep;
  } arc_cfg_t;

endpackage

/* src/arc_reg16.sv */
/*
  One sixteen-bit configuration register with byte strobes and a write mask.
  Assumes the caller gives a one-cycle write pulse on the clock pclk.
*/
module arc_reg16 #(
  parameter logic [15:0] WMASK = 16'hffff
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [1:0] strb,
  input wire logic [15:0] wdata,
  output logic [15:0] q
);

  // Byte-lane update; masked bits stay at their reset value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= arc_pkg::REG_RESET;
    end else if (wr) begin
      if (strb[0]) begin
        q[7:0] <= wdata[7:0] & WMASK[7:0];
      end
      if (strb[1]) begin
        q[15:8] <= wdata[15:8] & WMASK[15:8];
      end
    end
  end

endmodule

/* sim/tb_arc_cfg_regs.sv */
/*
  Self-checking bench for the range, common-mode, averaging and sleep bank.
  Assumes the package and the bank are compiled first; the bench is the APB master.
*/
module tb_arc_cfg_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0; // Bus clock at 200 MHz.
  logic presetn = 1'b0; // Reset, active low.
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  arc_pkg::arc_cfg_t cfg;
  int error_cnt = 0;
  int cmp_count = 0;

  arc_cfg_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg(cfg));

  // Half period of 2.5 ns.
  always #2.5 pclk = ~pclk;

  // Prints the counts and the verdict, then stops the run.
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Case inequality, so an unknown never passes.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Registers sit at four times their index.
  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      // A hung bus is a mismatch and ends the run.
      error_cnt++;
      final_report();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Write, judging the error response.
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
                    input logic e);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, s, rd, err);
    chk(err, e);
  endtask

  // Read, judging data and error response.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 16'h0, 4'h0, rd, err);
    chk(rd, exp);
    chk(err, e);
  endtask

  // Reset, then every register and every decoded field must read zero.
  task automatic t_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(cfg, '0);
    for (int i = 0; i < 4; i++) begin
      rd_chk(ra(arc_pkg::IDX_RANGE_LO + 8'(i)), 32'h0, 1'b0);
    end
    $display("reset test done");
  endtask

  // Every range code lands in every channel nibble, in both registers.
  task automatic t_ranges();
    logic [31:0] v;
    for (int c = 0; c < 6; c++) begin
      for (int n = 0; n < 8; n++) begin
        v[4*n +: 4] = 4'((c + n) % 6);
      end
      wr(ra(arc_pkg::IDX_RANGE_LO), v[15:0], 4'hf, 1'b0);
      wr(ra(arc_pkg::IDX_RANGE_HI), v[31:16], 4'hf, 1'b0);
      // The decoded copy trails the register by one edge.
      repeat (2) @(posedge pclk);
      chk(cfg.span_sel, v);
      rd_chk(ra(arc_pkg::IDX_RANGE_LO), {16'h0, v[15:0]}, 1'b0);
      rd_chk(ra(arc_pkg::IDX_RANGE_HI), {16'h0, v[31:16]}, 1'b0);
    end
    $display("range test done");
  endtask

  // Common-mode codes, wide enables, averaging and sleep, with reserved bits kept zero.
  task automatic t_cmode();
    logic [15:0] v;
    arc_pkg::arc_cfg_t e;
    e = cfg;
    for (int c = 0; c < 3; c++) begin
      v = {6'h00, 2'(2 - c), 2'(c), 2'(3 - c), c[0], ~c[0], c[0], ~c[0]};
      wr(ra(arc_pkg::IDX_CMODE), v, 4'hf, 1'b0);
      repeat (2) @(posedge pclk);
      e.cmode_span_low_group = v[arc_pkg::POS_CM_LO +: 2];
      e.cmode_span_high_group = v[arc_pkg::POS_CM_HI +: 2];
      e.wide_cmode_on_low_group = v[arc_pkg::POS_WIDE_LO];
      e.wide_cmode_on_high_group = v[arc_pkg::POS_WIDE_HI];
      e.averaging_setting_a = v[arc_pkg::POS_AVG_A];
      e.averaging_setting_b = v[arc_pkg::POS_AVG_B +: 2];
      e.full_device_sleep = v[arc_pkg::POS_SLEEP];
      chk(cfg, e);
      rd_chk(ra(arc_pkg::IDX_CMODE), {16'h0, v}, 1'b0);
    end
    $display("common-mode test done");
  endtask

  // Byte lanes on the last register, then unmapped and unaligned places.
  task automatic t_lanes_errors();
    wr(ra(arc_pkg::IDX_BOOST), 16'hbeef, 4'hf, 1'b0);
    wr(ra(arc_pkg::IDX_BOOST), 16'h1234, 4'h1, 1'b0);
    rd_chk(ra(arc_pkg::IDX_BOOST), 32'h0000be34, 1'b0);
    wr(ra(arc_pkg::IDX_BOOST), 16'h5600, 4'h2, 1'b0);
    wr(ra(8'hc6), 16'h0000, 4'hf, 1'b1);
    wr(12'h315, 16'h0000, 4'hf, 1'b1);
    rd_chk(ra(8'hc6), 32'h0, 1'b1);
    rd_chk(12'h000, 32'h0, 1'b1);
    rd_chk(ra(arc_pkg::IDX_BOOST), 32'h00005634, 1'b0);
    $display("lane and error test done");
  endtask

  // Main sequence; the second reset comes after the lane test, with every register left nonzero.
  initial begin
    t_reset();
    t_ranges();
    t_cmode();
    t_lanes_errors();
    t_reset();
    final_report();
  end
endmodule
